// File: rtl/relay_panel_defines.vh
`ifndef RELAY_PANEL_DEFINES_VH
`define RELAY_PANEL_DEFINES_VH

// ----------------------------------------
// Clock, press-duration and bus-monitor times
// ----------------------------------------
`define CLK_KHZ 25000
`define T_HALF_MS 500
`define T_ONE_MS 1000
`define T_FIVE_MS 5000
`define T_REPEAT_MS 200
`define T_MONITOR_MS 10

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFF_CTRL 12'h000
`define OFF_BFTIME 12'h004
`define OFF_PASSWORD 12'h008
`define OFF_STATUS 12'h00C
`define OFF_SETTING 12'h010
`define OFF_ADDRESS 12'h014

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_RATE 0
`define CTRL_BANK 1
`define CTRL_RETAIN 2
`define CTRL_CLEAR_REC 3
`define CTRL_CLEAR_LATCH 4

// ----------------------------------------
// Reset values, limits and password
// ----------------------------------------
`define RATE_RESET 1'b1
`define BANK_RESET 1'b0
`define RETAIN_RESET 1'b0
`define BFTIME_RESET 4'h2
`define BFTIME_MIN 4'h1
`define BFTIME_MAX 4'hA
`define SETTING_RESET 16'h0000
`define ADDRESS_RESET 8'h00
`define PASSWORD_VALUE 16'h0001

`endif

// File: rtl/press_timer.v
`timescale 1ns/1ns
// Measures how long one push-button is held and reports the release class.
module press_timer #(
	parameter HALF_CYC = 12500000,
	parameter ONE_CYC = 25000000,
	parameter FIVE_CYC = 125000000,
	parameter REP_CYC = 5000000
) (
	// Clock and reset.
	input wire mclk,
	input wire nrst,
	// Button level, high while pressed.
	input wire btn,
	// Press reports.
	output reg pressed,
	output reg released,
	output reg relUnderHalf,
	output reg relOneToFive,
	output reg atOne,
	output reg atFive,
	output reg repeatTick
);
	reg [26:0] cnt_q;
	reg [26:0] rep_q;

	// Duration counter saturates at five seconds so very long holds stay classed.
	always @(posedge mclk) begin
		if (!nrst) begin
			pressed <= 1'b0;
			released <= 1'b0;
			relUnderHalf <= 1'b0;
			relOneToFive <= 1'b0;
			atOne <= 1'b0;
			atFive <= 1'b0;
			repeatTick <= 1'b0;
			cnt_q <= 27'h000_0000;
			rep_q <= 27'h000_0000;
		end else begin
			pressed <= btn;
			released <= pressed & !btn;
			relUnderHalf <= pressed & !btn & (cnt_q < HALF_CYC[26:0]);
			relOneToFive <= pressed & !btn & (cnt_q >= ONE_CYC[26:0]) &
				(cnt_q < FIVE_CYC[26:0]);
			atOne <= btn & (cnt_q == ONE_CYC[26:0] - 27'h000_0001);
			atFive <= btn & (cnt_q == FIVE_CYC[26:0] - 27'h000_0001);
			repeatTick <= btn & (cnt_q >= ONE_CYC[26:0]) &
				(rep_q == REP_CYC[26:0] - 27'h000_0001);
			if (!btn)
				cnt_q <= 27'h000_0000;
			else if (cnt_q < FIVE_CYC[26:0])
				cnt_q <= cnt_q + 27'h000_0001;
			if (!btn || cnt_q < ONE_CYC[26:0] || rep_q == REP_CYC[26:0] - 27'h000_0001)
				rep_q <= 27'h000_0000;
			else
				rep_q <= rep_q + 27'h000_0001;
		end
	end
endmodule

// File: rtl/relay_panel_menu_control.v
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ns
`include "relay_panel_defines.vh"
// How it works
// [R01] Dark display, step held 1 s: first item.
// [R02] Dark display, short step press: last item.
// [R03] Step+reset, input or bus clears records.
// [R04] Supply restart clears records unless retention set.
// [R05] Settings, address, rate kept in non-volatile store.
// [R06] Data rate 4.8 or 9.6 kBd, default 9.6.
// [R07] Bus monitor 0 when healthy, else rolls 0-255.
// [R08] Bank select: 0 main, 1 second settings.
// [R09] Breaker-failure time 0.1 to 1.0 s, default 0.2.
// [R10] Register 0 digit encodes three control inputs.
// [R11] Test mode from register 0, one output each.
// [R12] Step press over 0.5 s advances one item.
// [R13] Holding step browses main menu rapidly.
// [R14] Step press under 0.5 s goes back one.
// [R15] Program 1 s enters submenu on release.
// [R16] Program 5 s toggles setting mode.
// [R17] Setting mode: step increments digit at cursor.
// [R18] Setting mode: program 1 s moves cursor.
// [R19] Setting mode: step+program stores the value.
// [R20] Otherwise step+program clears records and latches.
// [R21] Program releases latches only with display dark.
// [R22] Host sends password before setting writes.
module relay_panel_menu_control #(
	parameter MENU_ITEMS = 8,
	parameter SUB_ITEMS = 5,
	parameter TEST_OUTS = 4,
	parameter HALF_CYC = `T_HALF_MS * `CLK_KHZ,
	parameter ONE_CYC = `T_ONE_MS * `CLK_KHZ,
	parameter FIVE_CYC = `T_FIVE_MS * `CLK_KHZ,
	parameter REP_CYC = `T_REPEAT_MS * `CLK_KHZ,
	parameter MON_CYC = `T_MONITOR_MS * `CLK_KHZ
) (
	// Clock and reset.
	input wire mclk,
	input wire nrst,
	// APB slave.
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Front-panel buttons, high while pressed.
	input wire stepBtn,
	input wire progBtn,
	input wire resetBtn,
	// External control inputs and system status.
	input wire extBlockInputOne,
	input wire extBlockInputTwo,
	input wire remoteResetInput,
	input wire commOk,
	input wire supplyRestart,
	// Non-volatile store image.
	input wire nvLoad,
	input wire [31:0] nvLoadWord,
	output wire [31:0] nvWord,
	output reg nvSave,
	// Display and menu state.
	output reg displayOn,
	output reg [3:0] menuItem,
	output reg [3:0] subItem,
	output reg inSub,
	output reg setMode,
	output reg [1:0] cursor,
	output reg [15:0] editValue,
	output reg testMode,
	output reg [TEST_OUTS-1:0] testOutputs,
	// Actions and settings.
	output reg recordClear,
	output reg latchRelease,
	output reg rateFast,
	output reg bankSecond,
	output reg recordRetain,
	output reg [3:0] bfTime,
	output reg [15:0] settingValue,
	output reg [7:0] busAddress,
	output reg [7:0] monitorCount
);
	// ----------------------------------------
	// Button timers
	// ----------------------------------------
	wire sPressed, sRel, sShort, sOne, sRep;
	wire pPressed, pRel, pLong, pFive;
	reg resetHeld_q, comboSeen_q, stepUsed_q, progUsed_q, unlocked_q;
	reg [26:0] monDiv_q;
	reg [1:0] testSel_q;
	reg [TEST_OUTS-1:0] testNext;
	wire [2:0] ctlDigit;
	wire bothNow, stepResetNow, comboEv, quiet, lastItemSel;
	wire wrEn, wrSetting, rejectWr, unmapped;
	integer i;

	press_timer #(.HALF_CYC(HALF_CYC), .ONE_CYC(ONE_CYC), .FIVE_CYC(FIVE_CYC),
		.REP_CYC(REP_CYC)) stepTimer (
		.mclk(mclk), .nrst(nrst), .btn(stepBtn), .pressed(sPressed),
		.released(sRel), .relUnderHalf(sShort), .relOneToFive(),
		.atOne(sOne), .atFive(), .repeatTick(sRep)
	);

	press_timer #(.HALF_CYC(HALF_CYC), .ONE_CYC(ONE_CYC), .FIVE_CYC(FIVE_CYC),
		.REP_CYC(REP_CYC)) progTimer (
		.mclk(mclk), .nrst(nrst), .btn(progBtn), .pressed(pPressed),
		.released(pRel), .relUnderHalf(), .relOneToFive(pLong),
		.atOne(), .atFive(pFive), .repeatTick()
	);

	// ----------------------------------------
	// Button combinations
	// ----------------------------------------
	// A combination fires once on its rising edge; single-button actions stay
	// silenced until every button is up, so releasing one key does not act.
	assign bothNow = sPressed & pPressed;
	assign stepResetNow = sPressed & resetHeld_q;
	assign comboEv = (bothNow | stepResetNow) & !comboSeen_q;
	assign quiet = !comboSeen_q & !comboEv;
	assign lastItemSel = (menuItem == MENU_ITEMS[3:0] - 4'h1) & !inSub;

	// The control digit weights the three inputs 1, 2 and 4.
	assign ctlDigit = {remoteResetInput, extBlockInputTwo, extBlockInputOne}; // [R10]

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	assign pready = 1'b1;
	assign wrEn = psel & penable & pwrite;
	assign unmapped = (paddr != `OFF_CTRL) && (paddr != `OFF_BFTIME) &&
		(paddr != `OFF_PASSWORD) && (paddr != `OFF_STATUS) &&
		(paddr != `OFF_SETTING) && (paddr != `OFF_ADDRESS);
	assign wrSetting = wrEn & ((paddr == `OFF_CTRL) || (paddr == `OFF_BFTIME) ||
		(paddr == `OFF_SETTING) || (paddr == `OFF_ADDRESS));
	// Setting writes are refused until the password has been given.
	assign rejectWr = wrSetting & !unlocked_q; // [R22]
	assign pslverr = psel & penable & (unmapped | rejectWr);

	// Read multiplexer for the register file.
	always @* begin
		prdata = 32'h0000_0000;
		case (paddr)
			`OFF_CTRL: prdata[2:0] = {recordRetain, bankSecond, rateFast};
			`OFF_BFTIME: prdata[3:0] = bfTime;
			`OFF_PASSWORD: prdata[0] = unlocked_q;
			`OFF_STATUS: prdata = {6'h00, testMode, setMode, inSub, displayOn,
				testSel_q, subItem, menuItem, monitorCount, 1'b0, ctlDigit};
			`OFF_SETTING: prdata[15:0] = settingValue;
			`OFF_ADDRESS: prdata[7:0] = busAddress;
			default: prdata = 32'h0000_0000;
		endcase
	end

	// Packed image of everything the non-volatile store keeps.
	assign nvWord = {1'b0, recordRetain, bankSecond, bfTime, rateFast, busAddress, // [R04]
		settingValue};

	// One-hot drive of the output selected in test mode.
	always @* begin
		testNext = {TEST_OUTS{1'b0}};
		for (i = 0; i < TEST_OUTS; i = i + 1)
			testNext[i] = testMode & (testSel_q == i[1:0]); // [R11]
	end

	// ----------------------------------------
	// Bus monitor
	// ----------------------------------------
	// The count rolls freely while the link is unhealthy and parks at zero
	// once traffic is good again.
	always @(posedge mclk) begin
		if (!nrst) begin
			monDiv_q <= 27'h000_0000;
			monitorCount <= 8'h00;
		end else if (commOk) begin
			monDiv_q <= 27'h000_0000;
			monitorCount <= 8'h00; // [R07]
		end else if (monDiv_q == MON_CYC[26:0] - 27'h000_0001) begin
			monDiv_q <= 27'h000_0000;
			monitorCount <= monitorCount + 8'h01; // [R07]
		end else begin
			monDiv_q <= monDiv_q + 27'h000_0001;
		end
	end

	// ----------------------------------------
	// Settings registers and password
	// ----------------------------------------
	// Settings survive in the store image; a store load restores them.
	always @(posedge mclk) begin
		if (!nrst) begin
			rateFast <= `RATE_RESET; // [R06]
			bankSecond <= `BANK_RESET;
			recordRetain <= `RETAIN_RESET;
			bfTime <= `BFTIME_RESET; // [R09]
			busAddress <= `ADDRESS_RESET;
			settingValue <= `SETTING_RESET;
			unlocked_q <= 1'b0;
			nvSave <= 1'b0;
		end else begin
			nvSave <= 1'b0;
			if (nvLoad) begin
				settingValue <= nvLoadWord[15:0]; // [R05]
				busAddress <= nvLoadWord[23:16];
				rateFast <= nvLoadWord[24];
				bfTime <= nvLoadWord[28:25];
				bankSecond <= nvLoadWord[29];
				recordRetain <= nvLoadWord[30]; // [R04]
			end else if (setMode && bothNow && !comboSeen_q) begin
				settingValue <= editValue; // [R19]
				nvSave <= 1'b1; // [R05]
			end else if (wrSetting && !rejectWr) begin
				nvSave <= 1'b1; // [R05]
				case (paddr)
					`OFF_CTRL: begin
						rateFast <= pwdata[`CTRL_RATE]; // [R06]
						bankSecond <= pwdata[`CTRL_BANK]; // [R08]
						recordRetain <= pwdata[`CTRL_RETAIN];
					end
					`OFF_BFTIME: begin
						if (pwdata[31:4] == 28'h000_0000 && pwdata[3:0] >= `BFTIME_MIN &&
							pwdata[3:0] <= `BFTIME_MAX)
							bfTime <= pwdata[3:0]; // [R09]
					end
					`OFF_SETTING: settingValue <= pwdata[15:0];
					default: busAddress <= pwdata[7:0];
				endcase
			end
			if (wrEn && paddr == `OFF_PASSWORD)
				unlocked_q <= (pwdata[15:0] == `PASSWORD_VALUE); // [R22]
		end
	end

	// ----------------------------------------
	// Clear pulses
	// ----------------------------------------
	// Records clear from the panel, the remote input, the bus or a restart.
	always @(posedge mclk) begin
		if (!nrst) begin
			recordClear <= 1'b0;
			latchRelease <= 1'b0;
		end else begin
			recordClear <= (stepResetNow & !comboSeen_q) | remoteResetInput | // [R03]
				(wrEn & (paddr == `OFF_CTRL) & pwdata[`CTRL_CLEAR_REC]) | // [R03]
				(supplyRestart & !recordRetain) | // [R04]
				(bothNow & !comboSeen_q & !setMode); // [R20]
			latchRelease <= (bothNow & !comboSeen_q & !setMode) | // [R20]
				(pRel & quiet & !progUsed_q & !displayOn) | // [R21]
				(wrEn & (paddr == `OFF_CTRL) & pwdata[`CTRL_CLEAR_LATCH]);
		end
	end

	// ----------------------------------------
	// Menu and mode state
	// ----------------------------------------
	// All panel navigation; a hold that already acted marks its button used so
	// the later release is ignored.
	always @(posedge mclk) begin
		if (!nrst) begin
			resetHeld_q <= 1'b0;
			comboSeen_q <= 1'b0;
			stepUsed_q <= 1'b0;
			progUsed_q <= 1'b0;
			displayOn <= 1'b0;
			menuItem <= 4'h0;
			subItem <= 4'h0;
			inSub <= 1'b0;
			setMode <= 1'b0;
			cursor <= 2'b00;
			editValue <= 16'h0000;
			testMode <= 1'b0;
			testSel_q <= 2'b00;
			testOutputs <= {TEST_OUTS{1'b0}};
		end else begin
			resetHeld_q <= resetBtn;
			testOutputs <= testNext;
			if (bothNow | stepResetNow)
				comboSeen_q <= 1'b1;
			else if (!sPressed && !pPressed && !resetHeld_q)
				comboSeen_q <= 1'b0;
			if (sRel)
				stepUsed_q <= 1'b0;
			if (pRel)
				progUsed_q <= 1'b0;
			if (!displayOn) begin
				if (sOne && quiet) begin
					displayOn <= 1'b1;
					menuItem <= 4'h0; // [R01]
					stepUsed_q <= 1'b1;
				end else if (sRel && sShort && quiet && !stepUsed_q) begin
					displayOn <= 1'b1;
					menuItem <= MENU_ITEMS[3:0] - 4'h1; // [R02]
				end
			end else if (pFive && quiet) begin
				progUsed_q <= 1'b1;
				if (lastItemSel && !setMode)
					testMode <= !testMode; // [R11]
				else if (!testMode) begin
					setMode <= !setMode; // [R16]
					cursor <= 2'b00;
					editValue <= settingValue;
				end
			end else if (testMode) begin
				if (sRel && quiet)
					testSel_q <= (testSel_q == TEST_OUTS[1:0] - 2'b01) ? 2'b00 :
						testSel_q + 2'b01; // [R11]
			end else if (setMode) begin
				if (sRel && quiet) begin
					case (cursor)
						2'b00: editValue[3:0] <= (editValue[3:0] == 4'h9) ? 4'h0 :
							editValue[3:0] + 4'h1; // [R17]
						2'b01: editValue[7:4] <= (editValue[7:4] == 4'h9) ? 4'h0 :
							editValue[7:4] + 4'h1; // [R17]
						2'b10: editValue[11:8] <= (editValue[11:8] == 4'h9) ? 4'h0 :
							editValue[11:8] + 4'h1; // [R17]
						default: editValue[15:12] <= (editValue[15:12] == 4'h9) ? 4'h0 :
							editValue[15:12] + 4'h1; // [R17]
					endcase
				end else if (pRel && pLong && quiet && !progUsed_q) begin
					cursor <= cursor + 2'b01; // [R18]
				end
			end else if (sRep && quiet && !inSub) begin
				stepUsed_q <= 1'b1;
				menuItem <= (menuItem == MENU_ITEMS[3:0] - 4'h1) ? 4'h0 :
					menuItem + 4'h1; // [R13]
			end else if (sRel && quiet && !stepUsed_q) begin
				if (inSub) begin
					if (sShort)
						subItem <= (subItem == 4'h0) ? SUB_ITEMS[3:0] - 4'h1 :
							subItem - 4'h1; // [R14]
					else
						subItem <= (subItem == SUB_ITEMS[3:0] - 4'h1) ? 4'h0 :
							subItem + 4'h1; // [R12]
				end else if (sShort) begin
					menuItem <= (menuItem == 4'h0) ? MENU_ITEMS[3:0] - 4'h1 :
						menuItem - 4'h1; // [R14]
				end else begin
					menuItem <= (menuItem == MENU_ITEMS[3:0] - 4'h1) ? 4'h0 :
						menuItem + 4'h1; // [R12]
				end
			end else if (pRel && pLong && quiet && !progUsed_q) begin
				inSub <= !inSub; // [R15]
				subItem <= 4'h0;
			end
		end
	end
endmodule

// File: sim/relay_panel_checker.sv
`timescale 1ns/1ns
// ----------------------------------------
// Port checker of the panel controller
// ----------------------------------------
module relay_panel_checker #(
	parameter TEST_OUTS = 4
) (
	// Clock and reset.
	input wire mclk,
	input wire nrst,
	// Bus.
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pslverr,
	// Control inputs.
	input wire extBlockInputOne,
	input wire extBlockInputTwo,
	input wire remoteResetInput,
	input wire commOk,
	// Observed state.
	input wire testMode,
	input wire [TEST_OUTS-1:0] testOutputs,
	input wire recordClear,
	input wire rateFast,
	input wire bankSecond,
	input wire [3:0] bfTime,
	input wire [15:0] settingValue,
	input wire [7:0] monitorCount
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// Completed bus transfers by direction.
	wire rdAcc = psel && penable && !pwrite;
	wire wrAcc = psel && penable && pwrite;

	AST_RESET_DEFAULT: assert property (!$past(nrst) |-> rateFast && bfTime == 4'h2)
		else $error("defaults missing after reset");
	AST_BF_RANGE: assert property (bfTime >= 4'h1 && bfTime <= 4'hA)
		else $error("breaker time out of range");
	AST_CTRL_WRITE: assert property (
		wrAcc && paddr == 12'h000 && !pslverr |=> $past(pwdata[1:0]) == {bankSecond, rateFast})
		else $error("rate or bank not taken from write");
	AST_MON_HEALTHY: assert property (commOk |=> monitorCount == 8'h00)
		else $error("monitor not zero while healthy");
	AST_MON_STEP: assert property (
		monitorCount != $past(monitorCount)
		|-> monitorCount == 8'h00 || monitorCount == $past(monitorCount) + 8'h01)
		else $error("monitor jumped");
	AST_DIGIT: assert property (
		rdAcc && paddr == 12'h00C && $stable({remoteResetInput, extBlockInputTwo, extBlockInputOne})
		|-> prdata[2:0] == {remoteResetInput, extBlockInputTwo, extBlockInputOne})
		else $error("control digit wrong");
	AST_TEST_IDLE: assert property (!testMode && !$past(testMode) |-> testOutputs == '0)
		else $error("test output outside test mode");
	AST_TEST_SINGLE: assert property (testMode && $past(testMode) |-> $onehot0(testOutputs))
		else $error("several test outputs at once");
	AST_REMOTE_CLEAR: assert property (remoteResetInput |-> ##[1:2] recordClear)
		else $error("remote reset did not clear records");
	AST_LOCKED_SETTING: assert property (
		wrAcc && paddr == 12'h010 && pslverr |=> $stable(settingValue))
		else $error("refused setting write changed value");
endmodule

bind relay_panel_menu_control relay_panel_checker #(.TEST_OUTS(TEST_OUTS)) chk (.mclk, .nrst,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .extBlockInputOne,
	.extBlockInputTwo, .remoteResetInput, .commOk, .testMode, .testOutputs, .recordClear,
	.rateFast, .bankSecond, .bfTime, .settingValue, .monitorCount);

// File: sim/button_panel_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Operator push-buttons
// ----------------------------------------
module button_panel_model (
	// Clock.
	input wire mclk,
	// Buttons, high while pressed.
	output logic stepBtn,
	output logic progBtn,
	output logic resetBtn
);
	// Buttons rest released from time zero.
	initial begin
		{resetBtn, progBtn, stepBtn} = 3'b000;
	end
	// Holds the chosen buttons for n edges, then lets go and waits for the reaction.
	task automatic push(input logic [2:0] m, input int n);
		{resetBtn, progBtn, stepBtn} <= m;
		repeat (n) @(posedge mclk);
		{resetBtn, progBtn, stepBtn} <= 3'b000;
		repeat (4) @(posedge mclk);
	endtask
endmodule

// File: sim/relay_panel_menu_control_test.sv
`timescale 1ns/1ns
`include "relay_panel_defines.vh"
module relay_panel_menu_control_test;
	// ----------------------------------------
	// Signals and press lengths
	// ----------------------------------------
	// Press lengths against the shortened thresholds 10, 20 and 100 cycles.
	localparam int SHORT = 5, MID = 15, SUB = 30, WAKE = 22, BROWSE = 36, HOLD = 110;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, nvLoadWord = 32'h0000_0000, rd, w;
	logic extBlockInputOne = 1'b0, extBlockInputTwo = 1'b0, remoteResetInput = 1'b0;
	logic commOk = 1'b1, supplyRestart = 1'b0, nvLoad = 1'b0, er;
	wire stepBtn, progBtn, resetBtn, pready, pslverr, nvSave, displayOn, inSub, setMode;
	wire testMode, recordClear, latchRelease, rateFast, bankSecond, recordRetain;
	wire [31:0] prdata, nvWord;
	wire [3:0] menuItem, subItem, bfTime, testOutputs;
	wire [1:0] cursor;
	wire [15:0] editValue, settingValue;
	wire [7:0] busAddress, monitorCount;
	logic [3:0] t, e;
	logic [15:0] ev;
	logic [3:0] bv[4] = '{4'h0, 4'hA, 4'hB, 4'h1};
	int sl[4] = '{MID, SHORT, SHORT, MID};
	int ei[4] = '{1, 0, 7, 0};
	int nMismatch = 0, comparisons = 0, nClr = 0, nRel = 0, nSave = 0, k, j;

	relay_panel_menu_control #(.HALF_CYC(10), .ONE_CYC(20), .FIVE_CYC(100), .REP_CYC(4),
		.MON_CYC(5)) DUT (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .stepBtn, .progBtn, .resetBtn, .extBlockInputOne, .extBlockInputTwo,
		.remoteResetInput, .commOk, .supplyRestart, .nvLoad, .nvLoadWord, .nvWord, .nvSave,
		.displayOn, .menuItem, .subItem, .inSub, .setMode, .cursor, .editValue, .testMode,
		.testOutputs, .recordClear, .latchRelease, .rateFast, .bankSecond, .recordRetain,
		.bfTime, .settingValue, .busAddress, .monitorCount);
	button_panel_model pnl (.mclk, .stepBtn, .progBtn, .resetBtn);

	// Clock of 40 ns.
	always #20 mclk = ~mclk;
	// Counts record-clear, latch-release and store pulses.
	always @(posedge mclk) begin
		if (recordClear === 1'b1) nClr++;
		if (latchRelease === 1'b1) nRel++;
		if (nvSave === 1'b1) nSave++;
	end
	// Cuts a hang short.
	initial begin
		repeat (30000) @(posedge mclk);
		nMismatch++;
		printVerdict();
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			nMismatch++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic printVerdict();
		$display("mismatches %0d comparisons %0d", nMismatch, comparisons);
		if (nMismatch == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// One bus transfer; waits for pready, then idles a cycle.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			nMismatch++;
			printVerdict();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rdk(input string nm, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, rd, exp);
	endtask
	task automatic doReset();
		nrst <= 1'b0;
		repeat (3) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
	endtask
	// Decimal digit increment at the cursor, wrapping nine to zero.
	function automatic logic [15:0] bcdInc(input logic [15:0] v, input int c);
		v[c*4 +: 4] = (v[c*4 +: 4] == 4'h9) ? 4'h0 : v[c*4 +: 4] + 4'h1;
		return v;
	endfunction
	// Breaker time after a write: out-of-range values leave it alone.
	function automatic logic [3:0] bfNext(input logic [3:0] cur, input logic [3:0] v);
		return (v >= 4'h1 && v <= 4'hA) ? v : cur;
	endfunction

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(45472));
		doReset();
		rdk("ctrl", `OFF_CTRL, 32'h0000_0001);
		rdk("bftime", `OFF_BFTIME, 32'h0000_0002);
		j = nSave;
		apb(1'b1, `OFF_SETTING, 32'h0000_1234);
		chk("locked", {31'h0, er}, 1);
		rdk("setting", `OFF_SETTING, 0);
		chk("locked save", nSave - j, 0);
		apb(1'b1, `OFF_PASSWORD, {16'h0, `PASSWORD_VALUE});
		rdk("unlock", `OFF_PASSWORD, 1);
		for (int i = 0; i < 4; i++) begin
			w = $urandom & 32'h7FFF_FFFF;
			w[28:25] = 4'h1 + 4'($urandom_range(9));
			apb(1'b1, `OFF_SETTING, {16'h0, w[15:0]});
			apb(1'b1, `OFF_ADDRESS, {24'h0, w[23:16]});
			apb(1'b1, `OFF_BFTIME, {28'h0, w[28:25]});
			apb(1'b1, `OFF_CTRL, {29'h0, w[30], w[29], w[24]});
			chk("image", nvWord, w);
		end
		e = w[28:25];
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, `OFF_BFTIME, {28'h0, bv[i]});
			e = bfNext(e, bv[i]);
			chk("bftime", {28'h0, bfTime}, {28'h0, e});
		end
		apb(1'b0, 12'h018, 0);
		chk("unmapped", {er, rd[30:0]}, 32'h8000_0000);
		w = $urandom & 32'h7FFF_FFFF;
		w[28:25] = 4'h1 + 4'($urandom_range(9));
		nvLoadWord <= w;
		nvLoad <= 1'b1;
		@(posedge mclk);
		nvLoad <= 1'b0;
		repeat (2) @(posedge mclk);
		chk("restore", nvWord, w);
		for (int r = 0; r < 2; r++) begin
			apb(1'b1, `OFF_CTRL, {29'h0, 1'(r), w[29], w[24]});
			chk("retain", {31'h0, recordRetain}, r);
			k = nClr;
			supplyRestart <= 1'b1;
			@(posedge mclk);
			supplyRestart <= 1'b0;
			repeat (3) @(posedge mclk);
			chk("restart clear", nClr - k, 1 - r);
		end
		k = nClr;
		j = nRel;
		apb(1'b1, `OFF_CTRL, {27'h0, 2'b11, 1'b0, w[29], w[24]});
		repeat (2) @(posedge mclk);
		chk("bus clear", nClr - k, 1);
		chk("bus release", nRel - j, 1);
		for (int i = 0; i < 8; i++) begin
			{remoteResetInput, extBlockInputTwo, extBlockInputOne} <= 3'(i);
			repeat (2) @(posedge mclk);
			apb(1'b0, `OFF_STATUS, 0);
			chk("digit", {29'h0, rd[2:0]}, i);
		end
		{remoteResetInput, extBlockInputTwo, extBlockInputOne} <= 3'b000;
		commOk <= 1'b0;
		repeat (1300) @(posedge mclk);
		chk("monitor roll", {31'h0, monitorCount > 8'h00 && monitorCount < 8'h0A}, 1);
		commOk <= 1'b1;
		repeat (2) @(posedge mclk);
		chk("monitor ok", {24'h0, monitorCount}, 0);
		doReset();
		j = nRel;
		pnl.push(3'b010, SHORT);
		chk("dark release", nRel - j, 1);
		pnl.push(3'b001, SHORT);
		chk("dark short", {27'h0, displayOn, menuItem}, 32'h0000_0017);
		doReset();
		pnl.push(3'b001, WAKE);
		chk("dark long", {27'h0, displayOn, menuItem}, 32'h0000_0010);
		j = nRel;
		pnl.push(3'b010, SHORT);
		chk("lit release", nRel - j, 0);
		for (int i = 0; i < 4; i++) begin
			pnl.push(3'b001, sl[i]);
			chk("item", {28'h0, menuItem}, ei[i]);
		end
		pnl.push(3'b001, BROWSE);
		chk("browse", {31'h0, menuItem >= 4'h2}, 1);
		apb(1'b1, `OFF_PASSWORD, {16'h0, `PASSWORD_VALUE});
		apb(1'b1, `OFF_SETTING, 32'h0000_1239);
		if (menuItem === 4'h7) pnl.push(3'b001, MID);
		pnl.push(3'b010, SUB);
		chk("enter sub", {30'h0, inSub, subItem == 4'h0}, 3);
		pnl.push(3'b001, MID);
		chk("sub step", {28'h0, subItem}, 1);
		pnl.push(3'b010, SUB);
		chk("leave sub", {31'h0, inSub}, 0);
		pnl.push(3'b010, HOLD);
		chk("set entry", {13'h0, setMode, cursor, editValue}, 32'h0004_1239);
		ev = bcdInc(16'h1239, 0);
		pnl.push(3'b001, SHORT);
		chk("digit up", {16'h0, editValue}, {16'h0, ev});
		pnl.push(3'b010, SUB);
		chk("cursor", {30'h0, cursor}, 1);
		ev = bcdInc(ev, 1);
		pnl.push(3'b001, SHORT);
		chk("digit up", {16'h0, editValue}, {16'h0, ev});
		j = nSave;
		pnl.push(3'b011, SHORT);
		chk("store", {16'h0, settingValue}, {16'h0, ev});
		chk("store save", nSave - j, 1);
		pnl.push(3'b010, HOLD);
		chk("set exit", {31'h0, setMode}, 0);
		k = nClr;
		j = nRel;
		pnl.push(3'b011, SHORT);
		chk("panel clear", nClr - k, 1);
		chk("panel release", nRel - j, 1);
		pnl.push(3'b101, SHORT);
		chk("step reset", nClr - k, 2);
		for (int i = 0; i < 8 && menuItem !== 4'h7; i++) pnl.push(3'b001, MID);
		pnl.push(3'b010, HOLD);
		chk("test on", {31'h0, testMode}, 1);
		chk("one output", $countones(testOutputs), 1);
		t = testOutputs;
		pnl.push(3'b001, SHORT);
		chk("next output", {31'h0, testOutputs !== t && $countones(testOutputs) == 1}, 1);
		pnl.push(3'b010, HOLD);
		chk("test off", {27'h0, testMode, testOutputs}, 0);
		printVerdict();
	end
endmodule
